// File: verilog/spps_pkg.sv
/*
 * Shared constants and carrier types for the serial port pin setup block:
 * register offsets, field positions, reset values and the pin bundle.
 * Assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
package spps_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] ADR_CONTROL = 8'h00;
	localparam logic [7:0] ADR_PIN_CONTROL = 8'h04;
	localparam logic [7:0] ADR_SELECT_POL = 8'h08;
	localparam logic [7:0] ADR_CONTROL_TWO = 8'h0C;
	localparam logic [7:0] ADR_COMMAND_ZERO = 8'h10;
	localparam logic [7:0] ADR_PIN_MODE = 8'h14;
	localparam logic [7:0] ADR_OPEN_DRAIN = 8'h18;
	localparam logic [7:0] ADR_DIRECTION = 8'h1C;
	localparam logic [7:0] ADR_WRITE_PROTECT = 8'h20;
	localparam logic [7:0] ADR_FUNC_SEL_BASE = 8'h24;
	localparam logic [7:0] ADR_FUNC_SEL_LAST = 8'h30;
	localparam logic [7:0] ADR_DATA = 8'h34;
	localparam logic [7:0] ADR_STATUS = 8'h38;

	// ==========================================================
	// Field positions
	localparam int ENABLE_POS = 6;
	localparam int LOOP_POS = 0;
	localparam int LOOP_TWO_POS = 1;
	localparam int SEL_POL_POS = 0;
	localparam int PARITY_EN_POS = 0;
	localparam int IDLE_IRQ_EN_POS = 1;
	localparam int PHASE_POS = 0;
	localparam int POLARITY_POS = 1;
	localparam int LEN_LSB = 8;
	localparam int LEN_MSB = 11;
	localparam int ORDER_POS = 12;
	localparam int BLOCK_POS = 7;
	localparam int FSEL_WE_POS = 6;
	localparam int PIN_LSB = 2;
	localparam int PIN_MSB = 5;
	localparam int PSEL_MSB = 4;
	localparam int PIN_RX_ALT_POS = 0;
	localparam int ST_RX_VALID = 0;
	localparam int ST_OVERRUN = 1;
	localparam int ST_PARITY_ERR = 2;
	localparam int ST_UNDERRUN = 3;
	localparam int ST_TX_EMPTY = 4;
	localparam int ST_TX_FULL = 5;
	localparam int ST_FRAME = 6;
	localparam int ST_PIN_LSB = 8;

	// ==========================================================
	// Values and reset values
	localparam logic [4:0] PSEL_SERIAL = 5'h0D;
	localparam logic [3:0] LEN_32_CODE = 4'h2;
	localparam logic [5:0] LEN_32 = 6'h20;
	localparam logic [5:0] LEN_LONG_MIN = 6'h08;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_COMMAND = 16'h0000;
	localparam logic [7:0] RST_WRITE_PROTECT = 8'h80;
	localparam int FIFO_WIDTH = 32;
	localparam int FIFO_DEPTH = 16;

	// ==========================================================
	// Pin bundle, in the bit order of the pin mode register bits 5..2
	typedef struct packed {
		logic clock;
		logic select;
		logic data_out;
		logic data_in;
	} spps_pins_s;

endpackage

// File: verilog/spps_top.sv
/*
 * Serial channel in slave mode with its port pin routing, plus the transmit
 * FIFO that feeds it. Software reaches everything over classic Wishbone.
 * Assumes the far party drives the serial clock and select, both
 * asynchronous to clk and slow enough to be oversampled.
 */
// How it works
// - Enable bit cleared keeps the channel disabled.
// - Loopback bits cleared mean normal pin receive path.
// - Select polarity bit cleared makes select active low.
// - Parity bit cleared: no parity appended or checked.
// - Idle request only raised when its enable set.
// - Clock polarity set means clock idles high.
// - Phase set: change odd edges, sample even.
// - Length code 0010b gives 32-bit words.
// - Order bit cleared shifts most significant first.
// - Block bit set refuses write-enable bit changes.
// - Function selects writable only while write-enable set.
// - Function code 01101b routes pin to peripheral.
// - Mode bit set gives pin to peripheral.
// - Direction bit set makes pin an output.
// - Open-drain bit cleared drives push-pull.
// - Mode value picks pins per operating mode.
`timescale 1ns/1ps

// ==========================================================
// Synchronous FIFO
module spps_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;

	assign in_ready = (wr_ptr - rd_ptr) != (AW + 1)'(DEPTH);
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge clk)
	begin
		if (in_valid && in_ready)
		begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (in_valid && in_ready)
			begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (out_valid && out_ready)
			begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule

// ==========================================================
// Serial channel with pin routing
module spps_top (
	input wire logic clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire spps_pkg::spps_pins_s pin_in,
	output spps_pkg::spps_pins_s pin_out,
	output spps_pkg::spps_pins_s pin_oe,
	output logic idle_irq
);
	// ==========================================================
	// Helpers
	function automatic logic [5:0] word_len(input logic [3:0] code);
		if (code == spps_pkg::LEN_32_CODE || code < spps_pkg::LEN_LONG_MIN[3:0])
		begin
			word_len = spps_pkg::LEN_32;
		end
		else
		begin
			word_len = {2'b00, code} + 6'd1;
		end
	endfunction

	function automatic logic [4:0] bit_pos(input logic [5:0] c, input logic [5:0] len,
		input logic lsb_first);
		bit_pos = lsb_first ? c[4:0] : 5'(len - c - 6'd1);
	endfunction

	function automatic logic even_parity(input logic [31:0] w, input logic [5:0] len);
		logic [31:0] mask;
		mask = 32'hFFFFFFFF >> (6'd32 - len);
		even_parity = ^(w & mask);
	endfunction

	// ==========================================================
	// Registers
	logic [7:0] serial_control;
	logic [7:0] serial_pin_control;
	logic [7:0] select_polarity;
	logic [7:0] serial_control_two;
	logic [15:0] transfer_command_zero;
	logic [7:0] port_pin_mode;
	logic [7:0] port_open_drain;
	logic [7:0] port_direction;
	logic [7:0] pin_write_protect;
	logic [7:0] pin_function_select [4];

	logic peripheral_enable_bit;
	logic clock_phase_bit;
	logic clock_polarity_bit;
	logic parity_enable_bit;
	logic bit_order_bit;
	logic [5:0] len;
	logic [5:0] total;

	assign peripheral_enable_bit = serial_control[spps_pkg::ENABLE_POS];
	assign clock_phase_bit = transfer_command_zero[spps_pkg::PHASE_POS];
	assign clock_polarity_bit = transfer_command_zero[spps_pkg::POLARITY_POS];
	assign parity_enable_bit = serial_control_two[spps_pkg::PARITY_EN_POS];
	assign bit_order_bit = transfer_command_zero[spps_pkg::ORDER_POS];
	assign len = word_len(transfer_command_zero[spps_pkg::LEN_MSB:spps_pkg::LEN_LSB]);
	assign total = len + {5'd0, parity_enable_bit};

	// ==========================================================
	// Bus decode
	logic req;
	logic go;
	logic is_data;
	logic wr;
	logic rd_data;
	logic lo_en;
	logic hi_en;
	logic [31:0] rd_val;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [31:0] fifo_out_data;
	logic [3:0] fsel_idx;

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign is_data = wb_adr_i == spps_pkg::ADR_DATA;
	// A data write while the FIFO is full waits here: the stall is the back-pressure.
	assign go = req && !(wb_we_i && is_data && !fifo_in_ready);
	assign wr = go && wb_we_i;
	assign rd_data = go && !wb_we_i && is_data;
	assign lo_en = wb_sel_i[0];
	assign hi_en = wb_sel_i[1];
	assign fsel_idx = 4'((wb_adr_i - spps_pkg::ADR_FUNC_SEL_BASE) >> 2);

	// ==========================================================
	// Pin synchronisers and routing
	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic [3:0] psel_ok;
	logic [3:0] route;
	logic sck;
	logic sck_q;
	logic sel_act;
	logic sel_q;
	logic din;
	logic out_bit;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pin_s1 <= 4'h0;
			pin_s2 <= 4'h0;
		end
		else
		begin
			pin_s1 <= pin_in;
			pin_s2 <= pin_s1;
		end
	end

	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			psel_ok[i] = pin_function_select[i][spps_pkg::PSEL_MSB:0] == spps_pkg::PSEL_SERIAL;
		end
	end

	// The receive-only mode value sets bit 0 instead of the data-in bit, so either bit
	// hands the data-in pin to the channel.
	assign route = {port_pin_mode[spps_pkg::PIN_MSB:spps_pkg::PIN_LSB + 1],
		port_pin_mode[spps_pkg::PIN_LSB] | port_pin_mode[spps_pkg::PIN_RX_ALT_POS]}
		& psel_ok;
	// An unrouted clock pin looks idle, so the engine sees no edges from it.
	assign sck = route[3] ? pin_s2[3] : clock_polarity_bit;
	assign sel_act = peripheral_enable_bit && route[2]
		&& (select_polarity[spps_pkg::SEL_POL_POS] ? pin_s2[2] : !pin_s2[2]);
	always_comb
	begin
		if (serial_pin_control[spps_pkg::LOOP_POS])
		begin
			din = !out_bit;
		end
		else if (serial_pin_control[spps_pkg::LOOP_TWO_POS])
		begin
			din = out_bit;
		end
		else
		begin
			din = route[0] ? pin_s2[0] : 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sck_q <= 1'b1;
			sel_q <= 1'b0;
		end
		else
		begin
			sck_q <= sck;
			sel_q <= sel_act;
		end
	end

	// ==========================================================
	// Serial engine
	logic edge_seen;
	logic lead;
	logic shift_edge;
	logic sample_edge;
	logic start;
	logic frame;
	logic done;
	logic [5:0] cnt;
	logic [31:0] tx_word;
	logic [31:0] rx_word;
	logic [31:0] start_word;
	logic [31:0] next_rx_word;
	logic word_done;
	logic rx_par_bad;

	assign edge_seen = sck != sck_q;
	assign lead = edge_seen && (sck != clock_polarity_bit);
	assign shift_edge = frame && !done && (clock_phase_bit ? lead : edge_seen && !lead);
	assign sample_edge = frame && !done && (clock_phase_bit ? edge_seen && !lead : lead);
	assign start = sel_act && !sel_q;
	assign start_word = fifo_out_valid ? fifo_out_data : 32'h00000000;
	assign word_done = sample_edge && (cnt == total - 6'd1);
	assign rx_par_bad = parity_enable_bit && (din != even_parity(rx_word, len));

	always_comb
	begin
		next_rx_word = rx_word;
		if (cnt < len)
		begin
			next_rx_word[bit_pos(cnt, len, bit_order_bit)] = din;
		end
	end

	function automatic logic tx_bit(input logic [31:0] w, input logic [5:0] c);
		if (c < len)
		begin
			tx_bit = w[bit_pos(c, len, bit_order_bit)];
		end
		else
		begin
			tx_bit = even_parity(w, len);
		end
	endfunction

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			frame <= 1'b0;
			done <= 1'b0;
			cnt <= 6'd0;
			tx_word <= 32'h00000000;
			rx_word <= 32'h00000000;
			out_bit <= 1'b1;
		end
		else if (!sel_act)
		begin
			frame <= 1'b0;
			done <= 1'b0;
		end
		else if (start)
		begin
			frame <= 1'b1;
			done <= 1'b0;
			cnt <= 6'd0;
			tx_word <= start_word;
			rx_word <= 32'h00000000;
			if (!clock_phase_bit)
			begin
				out_bit <= tx_bit(start_word, 6'd0);
			end
		end
		else if (shift_edge)
		begin
			out_bit <= tx_bit(tx_word, cnt);
		end
		else if (sample_edge)
		begin
			rx_word <= next_rx_word;
			cnt <= cnt + 6'd1;
			done <= word_done;
		end
	end

	// ==========================================================
	// Transmit FIFO
	spps_fifo #(
		.WIDTH(spps_pkg::FIFO_WIDTH),
		.DEPTH(spps_pkg::FIFO_DEPTH)
	) u_tx_fifo (
		.clk(clk),
		.nrst(nrst),
		.in_valid(wr && is_data),
		.in_ready(fifo_in_ready),
		.in_data(wb_dat_i),
		.out_valid(fifo_out_valid),
		.out_ready(start),
		.out_data(fifo_out_data)
	);

	// ==========================================================
	// Status flags; a hardware set always beats a software clear.
	logic [31:0] rx_data;
	logic rx_valid;
	logic overrun;
	logic parity_err;
	logic underrun;
	logic w1c;

	assign w1c = wr && lo_en && wb_adr_i == spps_pkg::ADR_STATUS;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_data <= 32'h00000000;
			rx_valid <= 1'b0;
			overrun <= 1'b0;
			parity_err <= 1'b0;
			underrun <= 1'b0;
		end
		else
		begin
			if (word_done)
			begin
				rx_data <= parity_enable_bit ? rx_word : next_rx_word;
			end
			rx_valid <= word_done || (rx_valid && !rd_data);
			overrun <= (word_done && rx_valid && !rd_data)
				|| (overrun && !(w1c && wb_dat_i[spps_pkg::ST_OVERRUN]));
			parity_err <= (word_done && rx_par_bad)
				|| (parity_err && !(w1c && wb_dat_i[spps_pkg::ST_PARITY_ERR]));
			underrun <= (start && !fifo_out_valid)
				|| (underrun && !(w1c && wb_dat_i[spps_pkg::ST_UNDERRUN]));
		end
	end

	assign idle_irq = serial_control_two[spps_pkg::IDLE_IRQ_EN_POS]
		&& peripheral_enable_bit && !frame && !fifo_out_valid;

	// ==========================================================
	// Register writes
	logic cfg_open;

	// Channel setup is frozen while the channel runs.
	assign cfg_open = !peripheral_enable_bit;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			serial_control <= spps_pkg::RST_BYTE;
			serial_pin_control <= spps_pkg::RST_BYTE;
			select_polarity <= spps_pkg::RST_BYTE;
			serial_control_two <= spps_pkg::RST_BYTE;
			transfer_command_zero <= spps_pkg::RST_COMMAND;
		end
		else
		begin
			if (wr && lo_en)
			begin
				case (wb_adr_i)
					spps_pkg::ADR_CONTROL: serial_control <= wb_dat_i[7:0];
					spps_pkg::ADR_PIN_CONTROL: if (cfg_open) serial_pin_control <= wb_dat_i[7:0];
					spps_pkg::ADR_SELECT_POL: if (cfg_open) select_polarity <= wb_dat_i[7:0];
					spps_pkg::ADR_CONTROL_TWO: if (cfg_open) serial_control_two <= wb_dat_i[7:0];
					spps_pkg::ADR_COMMAND_ZERO:
					begin
						if (cfg_open)
						begin
							transfer_command_zero[7:0] <= wb_dat_i[7:0];
						end
					end
					default: ;
				endcase
			end
			if (wr && hi_en && cfg_open && wb_adr_i == spps_pkg::ADR_COMMAND_ZERO)
			begin
				transfer_command_zero[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			port_pin_mode <= spps_pkg::RST_BYTE;
			port_open_drain <= spps_pkg::RST_BYTE;
			port_direction <= spps_pkg::RST_BYTE;
			pin_write_protect <= spps_pkg::RST_WRITE_PROTECT;
			for (int i = 0; i < 4; i++)
			begin
				pin_function_select[i] <= spps_pkg::RST_BYTE;
			end
		end
		else if (wr && lo_en)
		begin
			case (wb_adr_i)
				spps_pkg::ADR_PIN_MODE: port_pin_mode <= wb_dat_i[7:0];
				spps_pkg::ADR_OPEN_DRAIN: port_open_drain <= wb_dat_i[7:0];
				spps_pkg::ADR_DIRECTION: port_direction <= wb_dat_i[7:0];
				spps_pkg::ADR_WRITE_PROTECT:
				begin
					pin_write_protect[spps_pkg::BLOCK_POS] <= wb_dat_i[spps_pkg::BLOCK_POS];
					if (!pin_write_protect[spps_pkg::BLOCK_POS])
					begin
						pin_write_protect[spps_pkg::FSEL_WE_POS] <= wb_dat_i[spps_pkg::FSEL_WE_POS];
					end
				end
				default:
				begin
					if (wb_adr_i >= spps_pkg::ADR_FUNC_SEL_BASE
						&& wb_adr_i <= spps_pkg::ADR_FUNC_SEL_LAST
						&& wb_adr_i[1:0] == 2'b00
						&& pin_write_protect[spps_pkg::FSEL_WE_POS])
					begin
						pin_function_select[fsel_idx[1:0]] <= wb_dat_i[7:0];
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Pin drivers
	logic [3:0] pin_val;
	logic [3:0] dir;
	logic [3:0] od;

	assign dir = port_direction[spps_pkg::PIN_MSB:spps_pkg::PIN_LSB];
	assign od = port_open_drain[spps_pkg::PIN_MSB:spps_pkg::PIN_LSB];
	// Only the data-out pin has a peripheral output; general outputs sit low.
	assign pin_val = {2'b00, route[1] && out_bit, 1'b0};
	assign pin_out = pin_val;
	assign pin_oe = dir & (~od | ~pin_val);

	// ==========================================================
	// Read mux and acknowledge
	always_comb
	begin
		rd_val = 32'h00000000;
		case (wb_adr_i)
			spps_pkg::ADR_CONTROL: rd_val[7:0] = serial_control;
			spps_pkg::ADR_PIN_CONTROL: rd_val[7:0] = serial_pin_control;
			spps_pkg::ADR_SELECT_POL: rd_val[7:0] = select_polarity;
			spps_pkg::ADR_CONTROL_TWO: rd_val[7:0] = serial_control_two;
			spps_pkg::ADR_COMMAND_ZERO: rd_val[15:0] = transfer_command_zero;
			spps_pkg::ADR_PIN_MODE: rd_val[7:0] = port_pin_mode;
			spps_pkg::ADR_OPEN_DRAIN: rd_val[7:0] = port_open_drain;
			spps_pkg::ADR_DIRECTION: rd_val[7:0] = port_direction;
			spps_pkg::ADR_WRITE_PROTECT: rd_val[7:0] = pin_write_protect;
			spps_pkg::ADR_DATA: rd_val = rx_data;
			spps_pkg::ADR_STATUS:
			begin
				rd_val[spps_pkg::ST_RX_VALID] = rx_valid;
				rd_val[spps_pkg::ST_OVERRUN] = overrun;
				rd_val[spps_pkg::ST_PARITY_ERR] = parity_err;
				rd_val[spps_pkg::ST_UNDERRUN] = underrun;
				rd_val[spps_pkg::ST_TX_EMPTY] = !fifo_out_valid;
				rd_val[spps_pkg::ST_TX_FULL] = !fifo_in_ready;
				rd_val[spps_pkg::ST_FRAME] = frame;
				rd_val[spps_pkg::ST_PIN_LSB +: 4] = pin_s2;
			end
			default:
			begin
				if (wb_adr_i >= spps_pkg::ADR_FUNC_SEL_BASE
					&& wb_adr_i <= spps_pkg::ADR_FUNC_SEL_LAST && wb_adr_i[1:0] == 2'b00)
				begin
					rd_val[7:0] = pin_function_select[fsel_idx[1:0]];
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= go;
			if (go && !wb_we_i)
			begin
				wb_dat_o <= rd_val;
			end
		end
	end
endmodule

// File: dv/spps_monitor.sv
/*
 * Checker for spps_top: bus handshake, pin drive and quiet request line.
 * Assumes it is bound to spps_top and sees only its ports.
 */
`timescale 1ns/1ps
module spps_monitor (
	input wire logic clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire spps_pkg::spps_pins_s pin_in,
	input wire spps_pkg::spps_pins_s pin_out,
	input wire spps_pkg::spps_pins_s pin_oe,
	input wire logic idle_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// ==========
	// Helper state
	logic req;
	logic [3:0] dir_sh;
	logic [3:0] od_sh;
	logic idle_seen;
	logic [3:0] since_fall;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

	// Shadows follow a write one edge late, so the checks skip the ack cycle.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			dir_sh <= 4'h0;
			od_sh <= 4'h0;
		end
		else if (wb_ack_o && wb_we_i && wb_sel_i[0])
		begin
			if (wb_adr_i == spps_pkg::ADR_DIRECTION)
				dir_sh <= wb_dat_i[5:2];
			if (wb_adr_i == spps_pkg::ADR_OPEN_DRAIN)
				od_sh <= wb_dat_i[5:2];
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			idle_seen <= 1'b0;
		else if (req && wb_we_i && wb_adr_i == spps_pkg::ADR_CONTROL_TWO && wb_dat_i[1])
			idle_seen <= 1'b1;
	end

	// A register write may reroute the data-out pin, so it restarts the count too.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			since_fall <= 4'hF;
		else if ($fell(pin_in.clock) || (req && wb_we_i))
			since_fall <= 4'h0;
		else if (since_fall != 4'hF)
			since_fall <= since_fall + 4'h1;
	end

	// ==========
	// Properties
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack stayed high for two cycles");
	chk_ack_prompt: assert property (req && !(wb_we_i && wb_adr_i == spps_pkg::ADR_DATA)
		|=> wb_ack_o)
		else $error("register access not answered in one cycle");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without a request");
	chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > spps_pkg::ADR_STATUS
		|-> wb_dat_o == 32'h0)
		else $error("unmapped read returned data");
	chk_narrow_upper: assert property (wb_ack_o && !wb_we_i
		&& wb_adr_i <= spps_pkg::ADR_FUNC_SEL_LAST && wb_adr_i != spps_pkg::ADR_COMMAND_ZERO
		|-> wb_dat_o[31:8] == 24'h0)
		else $error("narrow register read with upper bits set");
	chk_idle_quiet: assert property (!idle_seen |-> !idle_irq)
		else $error("idle request raised while never enabled");
	chk_oe_direction: assert property (!wb_ack_o |-> (pin_oe & ~dir_sh) == 4'h0)
		else $error("pin driven while its direction is input");
	chk_push_pull: assert property (!wb_ack_o && !od_sh[1]
		|-> pin_oe.data_out == dir_sh[1])
		else $error("push-pull data-out pin released");
	chk_out_after_edge: assert property ($changed(pin_out.data_out) |-> since_fall <= 4'h5)
		else $error("data-out changed away from a falling clock edge");

	cover property ($fell(pin_in.select));
	cover property (wb_ack_o && wb_we_i && wb_adr_i == spps_pkg::ADR_FUNC_SEL_BASE);
	cover property (req && wb_we_i && wb_adr_i == spps_pkg::ADR_DATA ##1 !wb_ack_o);
endmodule

bind spps_top spps_monitor u_mon (
	.clk(clk),
	.nrst(nrst),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.pin_in(pin_in),
	.pin_out(pin_out),
	.pin_oe(pin_oe),
	.idle_irq(idle_irq)
);

// File: dv/spps_link_model.sv
/*
 * Far-side audio party: makes serial clock and select, swaps one word a frame.
 * Assumes clock idles high, data changes on falling and is sampled on rising edges.
 */
`timescale 1ns/1ps
module spps_link_model (
	output logic sclk,
	output logic sel_n,
	output logic sdi,
	input wire logic sdo
);
	initial
	begin
		sclk = 1'b1;
		sel_n = 1'b1;
		sdi = 1'b0;
	end

	// The odd start offset keeps link edges away from system clock edges.
	task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
		rx = 32'h0;
		#13;
		sel_n = 1'b0;
		#160;
		for (int i = 31; i >= 0; i--)
		begin
			sclk = 1'b0;
			sdi = tx[i];
			#160;
			sclk = 1'b1;
			rx[i] = sdo;
			#160;
		end
		sel_n = 1'b1;
		sdi = ~sdi;
		#480;
	endtask
endmodule

// File: dv/tb_serial_port_pin_setup.sv
/*
 * Self-checking bench for spps_top: registers, pin setup, frames and FIFO.
 * Assumes spps_link_model as far party and the checker bound to the top.
 */
`timescale 1ns/1ps
module tb_serial_port_pin_setup;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	spps_pkg::spps_pins_s pin_in;
	spps_pkg::spps_pins_s pin_out;
	spps_pkg::spps_pins_s pin_oe;
	logic idle_irq;
	logic sclk, sel_n, sdi, do_line;
	logic do_last = 1'b0;
	logic [31:0] rd, got;
	int bad_count = 0;
	int n_tests = 0;
	localparam logic [7:0] MODES [3] = '{8'h3C, 8'h38, 8'h31};

	always #20 clk = ~clk;

	// A released data-out line shows the inverse of its last level, never a copy.
	always @*
		if (pin_oe.data_out)
			do_last = pin_out.data_out;
	assign do_line = pin_oe.data_out ? pin_out.data_out : ~do_last;
	assign pin_in = {sclk, sel_n, do_line, sdi};

	spps_top u_dut (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .idle_irq(idle_irq));
	spps_link_model u_link (.sclk(sclk), .sel_n(sel_n), .sdi(sdi), .sdo(do_line));

	// ==========
	// Tasks
	function automatic logic [31:0] tx_word(input int i);
		return 32'hA53C_0F00 ^ (32'(i) * 32'h0101_0107);
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hF;
		wb_dat_i <= dat;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 2000);
		if (n >= 2000)
			check("bus answer", 32'h0, 32'h1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		wb_cycle(1'b1, adr, dat);
	endtask

	task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
		wb_cycle(1'b0, adr, 32'h0);
		check($sformatf("register %h", adr), rd, exp);
	endtask

	task automatic final_report();
		if (bad_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		#1000000;
		bad_count++;
		final_report();
	end

	// ==========
	// Sequence
	initial
	begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		for (int a = 0; a <= 12; a++)
			rdchk(8'(a * 4), (a == 8) ? 32'h80 : 32'h0);
		wr(8'h3C, 32'hFFFF_FFFF);
		rdchk(8'h3C, 32'h0);
		wr(8'h24, 32'h0D);
		rdchk(8'h24, 32'h0);
		wr(8'h20, 32'h40);
		rdchk(8'h20, 32'h00);
		wr(8'h20, 32'h40);
		rdchk(8'h20, 32'h40);
		for (int a = 0; a < 4; a++)
		begin
			wr(8'(8'h24 + a * 4), 32'h0D);
			rdchk(8'(8'h24 + a * 4), 32'h0D);
		end
		wr(8'h20, 32'h80);
		rdchk(8'h20, 32'h80);
		wr(8'h2C, 32'h00);
		rdchk(8'h2C, 32'h0D);
		wr(8'h10, 32'h0203);
		rdchk(8'h10, 32'h0203);
		wr(8'h18, 32'h00);
		wr(8'h1C, 32'h08);
		check("output enables", 32'(pin_oe), 32'h2);
		wr(8'h14, 32'h3C);
		wr(8'h34, tx_word(0));
		u_link.frame(32'h1234_5678, got);
		wb_cycle(1'b0, 8'h38, 32'h0);
		check("rx valid", 32'(rd[0]), 32'h0);
		check("tx empty", 32'(rd[4]), 32'h0);
		wr(8'h00, 32'h40);
		wr(8'h10, 32'h0);
		rdchk(8'h10, 32'h0203);
		for (int i = 0; i < 3; i++)
		begin
			wr(8'h14, 32'(MODES[i]));
			if (i != 0 && MODES[i][3])
				wr(8'h34, tx_word(i));
			u_link.frame(~tx_word(i + 7), got);
			if (MODES[i][3])
				check("partner word", got, tx_word(i));
			wb_cycle(1'b0, 8'h38, 32'h0);
			check("parity error", 32'(rd[2]), 32'h0);
			if (MODES[i] != 8'h38)
			begin
				check("rx valid", 32'(rd[0]), 32'h1);
				rdchk(8'h34, ~tx_word(i + 7));
			end
			check("idle request", 32'(idle_irq), 32'h0);
			check("data-out enable", 32'(pin_oe.data_out), 32'h1);
		end
		wr(8'h14, 32'h3C);
		for (int i = 0; i < 16; i++)
			wr(8'h34, tx_word(i + 3));
		wb_cycle(1'b0, 8'h38, 32'h0);
		check("tx full", 32'(rd[5]), 32'h1);
		fork
			wr(8'h34, tx_word(19));
			u_link.frame(32'h0, got);
		join
		check("partner word", got, tx_word(3));
		for (int i = 4; i < 20; i++)
		begin
			u_link.frame(32'h0, got);
			check("partner word", got, tx_word(i));
		end
		wb_cycle(1'b0, 8'h38, 32'h0);
		check("tx empty", 32'(rd[4]), 32'h1);
		final_report();
	end
endmodule
